// ===== verilog/slser_consts.vh
// constants of the soft serializer transmitter and its start-up sequence
// Rules for this block and its clocking
// [R1] each word leaves its lane most significant bit first, least significant last
// [R2] channel count is a parameter, at most 18 per instance
// [R3] serialization factor is a parameter from one to ten bits
// [R4] external clock mode: fast clock on serial_clock_in, slow on parallel_clock_in
// [R5] external fast clock feeds only serial_clock_in; slow clock feeds parallel_clock_in
// [R6] an external clocking pll runs in source-synchronous compensation mode
// [R7] internal clock mode: own clock generator serves this instance alone
// [R8] pll reset held at least 10 ns, released, then lock awaited stable
// [R9] serial transfer starts only after lock has asserted and stayed stable
// [R10] clocking pll sits on the same die edge as the channel banks
// [R11] parallel rate is serial rate over factor; one word loaded per parallel cycle
`ifndef SLSER_CONSTS_VH
`define SLSER_CONSTS_VH
`define SLSER_CLK_PERIOD_NS   10
`define SLSER_RST_MIN_NS      10
`define SLSER_RST_CYC         ((`SLSER_RST_MIN_NS + `SLSER_CLK_PERIOD_NS - 1) / `SLSER_CLK_PERIOD_NS)
`define SLSER_LOCK_STABLE_CYC 16
`define SLSER_MAX_CHANNELS    18
`define SLSER_MAX_FACTOR      10
`define SLSER_CHANNELS        4
`define SLSER_FACTOR          8
`define SLSER_FIFO_DEPTH      16
`define SLSER_ST_RESET        2'h0
`define SLSER_ST_WAIT         2'h1
`define SLSER_ST_RUN          2'h2
`endif

// ===== verilog/slser_tx.v
// soft serializer transmitter with word fifo and pll start-up control
`include "slser_consts.vh"

// ==========================================================
// word fifo
module slser_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // slser_fifo

// ==========================================================
// transmitter top
module slser_tx #(
  parameter CHANNELS = `SLSER_CHANNELS,
  parameter FACTOR   = `SLSER_FACTOR
) (
  // clock and reset
  input  wire                         clk,
  input  wire                         nrst,
  // link clocks, sampled as plain inputs
  input  wire                         serial_clock_in,
  input  wire                         parallel_clock_in,
  // pll control
  output wire                         pll_async_reset,
  input  wire                         pll_locked,
  // parallel words from core logic
  input  wire                         word_valid,
  output wire                         word_ready,
  input  wire [CHANNELS*FACTOR-1:0]   word_data,
  // serial lanes and status
  output wire [CHANNELS-1:0]          tx_serial,
  output wire                         tx_ready
);
  localparam W = CHANNELS * FACTOR;
  // out-of-range settings give a negative replication below and fail elaboration
  localparam CHK = (CHANNELS >= 1 && CHANNELS <= `SLSER_MAX_CHANNELS && FACTOR >= 1 &&
                    FACTOR <= `SLSER_MAX_FACTOR) ? 1 : 0; // [R2] [R3]
  wire range_ok;
  assign range_ok = {(2*CHK-1){1'b1}}; // [R2] [R3]

  // ==========================================================
  // synchronisers and edge finding
  reg [1:0] sclk_s_q;
  reg [1:0] pclk_s_q;
  reg [1:0] lock_s_q;
  reg       sclk_p_q;
  reg       pclk_p_q;
  wire      sclk_rise;
  wire      pclk_rise;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s_q <= 2'h0;
      pclk_s_q <= 2'h0;
      lock_s_q <= 2'h0;
      sclk_p_q <= 1'b0;
      pclk_p_q <= 1'b0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], serial_clock_in};
      pclk_s_q <= {pclk_s_q[0], parallel_clock_in};
      lock_s_q <= {lock_s_q[0], pll_locked};
      sclk_p_q <= sclk_s_q[1];
      pclk_p_q <= pclk_s_q[1];
    end
  end
  assign sclk_rise = sclk_s_q[1] & ~sclk_p_q;
  assign pclk_rise = pclk_s_q[1] & ~pclk_p_q;

  // ==========================================================
  // start-up sequence
  localparam [1:0] ST_RESET = `SLSER_ST_RESET;
  localparam [1:0] ST_WAIT  = `SLSER_ST_WAIT;
  localparam [1:0] ST_RUN   = `SLSER_ST_RUN;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  reg       rst_q;
  reg       rdy_q;
  wire      lock_ok;

  assign lock_ok = lock_s_q[1];

  always @*
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_RESET:
      begin
        cnt_d = cnt_q + 5'h01;
        if ((cnt_q + 5'h01) >= `SLSER_RST_CYC) // [R8]
        begin
          st_d  = ST_WAIT;
          cnt_d = 5'h00;
        end
      end
      ST_WAIT:
      begin
        if (!lock_ok)
          cnt_d = 5'h00;
        else if (cnt_q == (`SLSER_LOCK_STABLE_CYC - 1)) // [R8]
          st_d = ST_RUN;
        else
          cnt_d = cnt_q + 5'h01;
      end
      ST_RUN:
      begin
        // lost lock restarts the pll
        if (!lock_ok)
        begin
          st_d  = ST_RESET;
          cnt_d = 5'h00;
        end
      end
      default:
      begin
        st_d  = ST_RESET;
        cnt_d = 5'h00;
      end
    endcase
  end

  // outputs come from their own flops: a two-bit state change must not glitch the pll reset
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q  <= ST_RESET;
      cnt_q <= 5'h00;
      rst_q <= 1'b1;
      rdy_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      rst_q <= (st_d == ST_RESET); // [R7] [R8]
      rdy_q <= (st_d == ST_RUN) & range_ok; // [R9]
    end
  end

  assign pll_async_reset = rst_q; // [R7] [R8]
  assign tx_ready        = rdy_q; // [R9]

  // ==========================================================
  // word buffer
  wire         f_valid;
  wire         f_ready;
  wire [W-1:0] f_data;
  wire         load;

  slser_fifo #(
    .WIDTH (W),
    .DEPTH (`SLSER_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // one word per parallel clock edge; an empty buffer sends zeros
  assign load    = tx_ready & pclk_rise; // [R9] [R11]
  assign f_ready = load;

  // ==========================================================
  // shift registers, one per lane
  // the parallel clock rises with a serial rise, so the load edge is a serial edge too:
  // it sends the msb at once and each word fills exactly FACTOR serial bits;
  // a parallel rise that slips off its serial rise cuts that word short
  reg [W-1:0]        sh_q;
  reg [CHANNELS-1:0] out_q;
  wire [W-1:0]       ld_word;
  integer            i;

  assign ld_word = f_valid ? f_data : {W{1'b0}}; // [R11]

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_q  <= {W{1'b0}};
      out_q <= {CHANNELS{1'b0}};
    end
    else if (!tx_ready)
    begin
      sh_q  <= {W{1'b0}};
      out_q <= {CHANNELS{1'b0}};
    end
    else if (load)
    begin
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        out_q[i] <= ld_word[i*FACTOR + FACTOR - 1]; // [R1] [R11]
        sh_q[i*FACTOR +: FACTOR] <= ld_word[i*FACTOR +: FACTOR] << 1; // [R1] [R11]
      end
    end
    else if (sclk_rise)
    begin
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        out_q[i] <= sh_q[i*FACTOR + FACTOR - 1]; // [R1]
        sh_q[i*FACTOR +: FACTOR] <= sh_q[i*FACTOR +: FACTOR] << 1; // [R1]
      end
    end
  end

  assign tx_serial = out_q;
endmodule // slser_tx

// ===== tb/slser_rx_model.sv
// far-side serial receiver model
module slser_rx_model #(
  parameter CH = 4,
  parameter FW = 8
) (
  input  wire logic          sclk,
  input  wire logic          pclk,
  input  wire logic [CH-1:0] ser,
  output logic [CH*FW-1:0]   word,
  output int                 cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CH*FW-1:0] sh = '0;
  logic             pclk_q = 1'b0;
  initial word = '0;
  initial cnt = 0;
  // sample mid-bit; msb comes first so shifting left rebuilds the word;
  // a parallel rise since the last sample is a word boundary, so the finished
  // word is handed over before the new word's msb is shifted in
  always @(negedge sclk)
  begin
    if (pclk && !pclk_q)
    begin
      word = sh;
      cnt++;
    end
    pclk_q = pclk;
    for (int i = 0; i < CH; i++) sh[i*FW +: FW] = {sh[i*FW +: FW-1], ser[i]};
  end
endmodule // slser_rx_model

// ===== tb/slser_tx_chk.sv
// assertions on the transmitter top ports
module slser_tx_chk #(
  parameter CHANNELS = 4,
  parameter FACTOR   = 8
) (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                serial_clock_in,
  input wire logic                pll_async_reset,
  input wire logic                pll_locked,
  input wire logic [CHANNELS-1:0] tx_serial,
  input wire logic                tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lock_q;
  // run length of lock at the pin; saturates so it never wraps
  always @(posedge clk or negedge nrst)
    if (!nrst) lock_q <= 6'h00;
    else if (!pll_locked) lock_q <= 6'h00;
    else if (lock_q != 6'h3f) lock_q <= lock_q + 6'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ready_lock; $rose(tx_ready) |-> lock_q >= 6'h10; endproperty
  a_ready_lock: assert property (p_ready_lock) else $error("ready before stable lock");
  property p_ready_rst; tx_ready |-> !pll_async_reset; endproperty
  a_ready_rst: assert property (p_ready_rst) else $error("ready while pll in reset");
  property p_idle_zero; !tx_ready && $past(!tx_ready) |-> tx_serial == '0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("lanes busy while not ready");
  property p_loss_drop; $fell(pll_locked) |-> ##[1:3] !tx_ready; endproperty
  a_loss_drop: assert property (p_loss_drop) else $error("ready kept after lock loss");
  property p_restart; $fell(tx_ready) |-> pll_async_reset; endproperty
  a_restart: assert property (p_restart) else $error("lock loss did not reset the pll");
  property p_shift_edge;
    tx_ready && $past(tx_ready) && $changed(tx_serial) |-> $past(serial_clock_in, 2) || $past(serial_clock_in, 3);
  endproperty
  a_shift_edge: assert property (p_shift_edge) else $error("lane moved off serial edge");
  c_ready: cover property ($rose(tx_ready));
  c_loss: cover property ($fell(tx_ready));
  c_shift: cover property (tx_ready && $changed(tx_serial));
endmodule // slser_tx_chk
bind slser_tx slser_tx_chk #(.CHANNELS(CHANNELS), .FACTOR(FACTOR)) u_slser_tx_chk (.clk(clk), .nrst(nrst),
  .serial_clock_in(serial_clock_in), .pll_async_reset(pll_async_reset), .pll_locked(pll_locked),
  .tx_serial(tx_serial), .tx_ready(tx_ready));

// ===== tb/tb.sv
// self-checking bench for the serializer transmitter
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam CH = 4, FW = 8, NR = 16;
  logic             clk = 0, nrst = 0, sclk = 0, pclk = 0, pll_locked = 0, word_valid = 0;
  logic [CH*FW-1:0] word_data = '0, rx_word;
  logic [CH*FW-1:0] rows [NR];
  logic [CH-1:0]    tx_serial;
  logic             pll_async_reset, word_ready, tx_ready;
  int               errors = 0, cmp_count = 0, rx_cnt, k = 0;
  always #5 clk = ~clk;
  // link clock offset in phase from the system clock
  initial #3 forever #40 sclk = ~sclk;
  // one source makes both link clocks; slow is fast over the factor, rising together
  always @(posedge sclk)
  begin
    k++;
    if (k % (FW/2) == 0) pclk = ~pclk;
  end
  slser_tx #(.CHANNELS(CH), .FACTOR(FW)) u_slser_tx (.clk(clk), .nrst(nrst), .serial_clock_in(sclk),
    .parallel_clock_in(pclk), .pll_async_reset(pll_async_reset), .pll_locked(pll_locked),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .tx_serial(tx_serial),
    .tx_ready(tx_ready));
  slser_rx_model #(.CH(CH), .FW(FW)) u_slser_rx_model (.sclk(sclk), .pclk(pclk), .ser(tx_serial),
    .word(rx_word), .cnt(rx_cnt));
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic push(input logic [CH*FW-1:0] d);
    @(negedge clk);
    word_valid = 1;
    word_data = d;
    while (word_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    word_valid = 0;
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run is some 25 frames of 640 ns; far below this
  initial
  begin
    #300000;
    errors++;
    finish_test;
  end
  initial
  begin
    // each row is a word in and the same word expected across the lanes
    for (int i = 0; i < NR; i++) rows[i] = {8'h80 | 8'(i), 8'h01 << (i % 8), ~8'(i), 8'(i) * 8'h11};
    repeat (10) @(negedge clk);
    check(pll_async_reset === 1'b1 && tx_ready === 1'b0 && tx_serial === '0, "reset state");
    $display("test reset state done");
    nrst = 1;
    // fill the buffer while unlocked: it must refuse the 17th, send nothing
    for (int i = 0; i < NR; i++) push(rows[i]);
    check(word_ready === 1'b0, "full buffer still ready");
    repeat (100) @(negedge clk);
    check(tx_ready === 1'b0 && tx_serial === '0 && pll_async_reset === 1'b0, "sent before lock");
    $display("test unlocked fill done");
    pll_locked = 1;
    repeat (12) @(negedge clk);
    check(tx_ready === 1'b0, "ready too early");
    for (int w = 0; w < 40 && tx_ready !== 1'b1; w++) @(negedge clk);
    check(tx_ready === 1'b1, "not ready after lock");
    for (int w = 0; w < 8 && rx_word === '0; w++) @(rx_cnt);
    for (int i = 0; i < NR; i++)
    begin
      if (i > 0) @(rx_cnt);
      check(rx_word === rows[i], $sformatf("row %0d got %h", i, rx_word));
    end
    @(rx_cnt);
    @(rx_cnt);
    check(rx_word === '0, "empty buffer sent data");
    $display("test row stream done");
    pll_locked = 0;
    repeat (8) @(negedge clk);
    check(tx_ready === 1'b0 && tx_serial === '0, "lock loss");
    $display("test lock loss done");
    // mid-run reset drops a buffered word and restarts the pll sequence
    push(rows[0]);
    nrst = 0;
    @(negedge clk);
    check(pll_async_reset === 1'b1 && tx_ready === 1'b0 && word_ready === 1'b1, "mid-run reset");
    nrst = 1;
    repeat (2) @(negedge clk);
    pll_locked = 1;
    for (int w = 0; w < 40 && tx_ready !== 1'b1; w++) @(negedge clk);
    check(tx_ready === 1'b1, "not ready after second lock");
    @(rx_cnt);
    @(rx_cnt);
    check(rx_word === '0, "reset left a word behind");
    $display("test mid-run reset done");
    finish_test;
  end
endmodule // tb
